// ### rtl/srf_pkg.sv
// Shared constants and types for the serial receive input filter
package srf_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int MS_IN_NS        = 1000000;
    localparam int CYC_PER_MS      = MS_IN_NS / CLK_PERIOD_NS;
    localparam int CLK_FREQ_HZ     = 100000000;
    localparam int BAUD_DEFAULT    = 9600;
    localparam int CLKS_PER_BIT    = CLK_FREQ_HZ / BAUD_DEFAULT;
    localparam int PRESC_W         = 17;
    localparam int BIT_CNT_W       = 16;

    // Action list geometry
    localparam int LIT_MAX         = 6;
    localparam int PAT_BYTES       = 16;
    localparam int TMO_W           = 16;
    localparam int ENTRY_W         = 25;

    // Character codes, decimal radix, zero byte and buffer depth
    localparam logic [7:0]  ASCII_ZERO = 8'h30;
    localparam logic [7:0]  ASCII_NINE = 8'h39;
    localparam logic [15:0] DEC_RADIX  = 16'h000A;
    localparam logic [7:0]  ZERO_BYTE  = 8'h00;
    localparam logic [1:0]  BUF_DEPTH  = 2'h2;

    // Input action codes
    typedef enum logic [2:0] {
        OP_CAPTURE   = 3'h0,
        OP_WAIT_LIT  = 3'h1,
        OP_WAIT_ARR  = 3'h2,
        OP_SKIP      = 3'h3,
        OP_DEC_FIXED = 3'h4,
        OP_DEC_VAR   = 3'h5
    } srf_op_type;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_FETCH = 2'h1,
        ST_RUN   = 2'h2,
        ST_FILL  = 2'h3
    } srf_state_type;
endpackage

// ### rtl/srf_frame_rx.sv
// Asynchronous frame deserialiser with optional even parity check
`timescale 1ns/1ns
module srf_frame_rx
    import srf_pkg::*;
#(
    parameter int CLKS_PER_BIT_P = CLKS_PER_BIT
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       rx_pin,
    input  wire logic       seven_bit,
    input  wire logic       parity_en,
    output logic            byte_valid,
    output logic [7:0]      byte_data,
    output logic            byte_perr
);
    typedef struct packed {
        logic                 s1;
        logic                 s2;
        logic                 busy;
        logic [BIT_CNT_W-1:0] cnt;
        logic [3:0]           bitn;
        logic [8:0]           sh;
        logic                 valid;
        logic [7:0]           data;
        logic                 perr;
    } srf_rx_type;

    localparam logic [BIT_CNT_W-1:0] FULL_BIT = BIT_CNT_W'(CLKS_PER_BIT_P - 1);
    localparam logic [BIT_CNT_W-1:0] HALF_BIT = BIT_CNT_W'(CLKS_PER_BIT_P / 2);

    srf_rx_type r_r;
    srf_rx_type r_nxt;
    logic [3:0] nbits;
    logic [8:0] aligned;

    // Frame walk: start check, data and parity bits LSB first, then stop
    always_comb begin
        r_nxt       = r_r;
        r_nxt.s1    = rx_pin;
        r_nxt.s2    = r_r.s1;
        r_nxt.valid = 1'b0;
        nbits   = (seven_bit ? 4'h7 : 4'h8) + {3'h0, parity_en};
        aligned = r_r.sh >> (4'h9 - nbits);
        if (!r_r.busy) begin
            if (!r_r.s2) begin
                r_nxt.busy = 1'b1;
                r_nxt.cnt  = HALF_BIT;
                r_nxt.bitn = 4'h0;
            end
        end else if (r_r.cnt != '0) begin
            r_nxt.cnt = r_r.cnt - 1'b1;
        end else begin
            r_nxt.cnt  = FULL_BIT;
            r_nxt.bitn = r_r.bitn + 1'b1;
            if (r_r.bitn == 4'h0) begin
                r_nxt.busy = !r_r.s2; // Glitch on start bit is dropped
            end else if (r_r.bitn <= nbits) begin
                r_nxt.sh = {r_r.s2, r_r.sh[8:1]};
            end else begin
                // Stop bit slot: hand the byte over as one pulse
                r_nxt.busy  = 1'b0;
                r_nxt.valid = 1'b1;
                r_nxt.data  = seven_bit ? {1'b0, aligned[6:0]} : aligned[7:0];
                r_nxt.perr  = parity_en &&
                    ((^(seven_bit ? {1'b0, aligned[6:0]} : aligned[7:0]))
                     ^ aligned[nbits-4'h1]);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_r <= '{s1: 1'b1, s2: 1'b1, default: '0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign byte_valid = r_r.valid;
    assign byte_data  = r_r.data;
    assign byte_perr  = r_r.perr;
endmodule

// ### rtl/srf_input_filter.sv
// Receive-side input action sequencer with parity and inactivity exits
`timescale 1ns/1ns
module srf_input_filter
    import srf_pkg::*;
#(
    parameter int CLKS_PER_BIT_P = CLKS_PER_BIT,
    parameter int CYC_PER_MS_P   = CYC_PER_MS
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   rx_pin,
    input  wire logic                   seven_bit,
    input  wire logic                   parity_en,
    input  wire logic [TMO_W-1:0]       timeout_ms,
    input  wire logic                   op_start,
    output logic                        op_busy,
    input  wire logic                   act_valid,
    output logic                        act_ready,
    input  wire logic [2:0]             act_op,
    input  wire logic [7:0]             act_count,
    input  wire logic                   act_end_en,
    input  wire logic [7:0]             act_end_char,
    input  wire logic [PAT_BYTES*8-1:0] act_pattern,
    input  wire logic                   act_last,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic [7:0]                  out_addr,
    output logic [15:0]                 out_data,
    output logic                        out_is_value,
    output logic                        done_pulse,
    output logic                        parity_exit,
    output logic                        timeout_exit
);
    typedef struct packed {
        srf_state_type        st;
        srf_op_type           op;
        logic [7:0]           count;
        logic [7:0]           len;
        logic [7:0]           idx;
        logic                 end_en;
        logic [7:0]           end_char;
        logic [PAT_BYTES*8-1:0] pat;
        logic                 last;
        logic [15:0]          acc;
        logic [TMO_W-1:0]     ms_cnt;
        logic [PRESC_W-1:0]   presc;
        logic                 done;
        logic                 perr;
        logic                 tmo;
        logic [ENTRY_W-1:0]   e0;
        logic [ENTRY_W-1:0]   e1;
        logic [1:0]           bcnt;
    } srf_seq_type;

    localparam logic [PRESC_W-1:0] PRESC_TOP = PRESC_W'(CYC_PER_MS_P - 1);

    srf_seq_type r_r;
    srf_seq_type r_nxt;

    logic               bv;
    logic [7:0]         bd;
    logic               bp;
    logic               push;
    logic [ENTRY_W-1:0] push_w;
    logic               pop;
    logic               room;
    logic               fin;
    logic               is_digit;
    logic [15:0]        dec_next;
    logic [7:0]         plen;
    logic [7:0]         pbyte;

    srf_frame_rx #(
        .CLKS_PER_BIT_P (CLKS_PER_BIT_P)
    ) u_rx (
        .clk        (clk),
        .rst        (rst),
        .rx_pin     (rx_pin),
        .seven_bit  (seven_bit),
        .parity_en  (parity_en),
        .byte_valid (bv),
        .byte_data  (bd),
        .byte_perr  (bp)
    );

    // Sequencer, timers and the two-entry output buffer
    always_comb begin
        r_nxt       = r_r;
        r_nxt.done  = 1'b0;
        r_nxt.perr  = 1'b0;
        r_nxt.tmo   = 1'b0;
        push        = 1'b0;
        push_w      = '0;
        fin         = 1'b0;
        pop         = (r_r.bcnt != 2'h0) && out_ready;
        // A full buffer stalls the sequencer; a byte arriving then is lost
        room        = (r_r.bcnt != BUF_DEPTH) || pop;
        is_digit    = (bd >= ASCII_ZERO) && (bd <= ASCII_NINE);
        dec_next    = 16'(r_r.acc * DEC_RADIX + {8'h00, bd - ASCII_ZERO});
        pbyte       = r_r.pat[r_r.idx[3:0]*8 +: 8];
        // Pattern length of the action being fetched
        plen = act_count;
        if (act_op == OP_WAIT_LIT && act_count > 8'(LIT_MAX)) begin
            plen = 8'(LIT_MAX);
        end
        if (act_op == OP_WAIT_ARR && act_count == ZERO_BYTE) begin
            plen = 8'(PAT_BYTES);
            for (int i = PAT_BYTES - 1; i >= 0; i--) begin
                if (act_pattern[i*8 +: 8] == ZERO_BYTE) begin
                    plen = 8'(i);
                end
            end
        end
        if (act_op == OP_DEC_VAR) begin
            plen = 8'h01;
        end

        case (r_r.st)
            ST_IDLE: begin
                if (op_start) begin
                    r_nxt.st     = ST_FETCH;
                    r_nxt.ms_cnt = '0;
                    r_nxt.presc  = '0;
                end
            end
            ST_FETCH: begin
                if (act_valid) begin
                    r_nxt.op       = srf_op_type'(act_op);
                    r_nxt.count    = act_count;
                    r_nxt.len      = plen;
                    r_nxt.end_en   = act_end_en;
                    r_nxt.end_char = act_end_char;
                    r_nxt.pat      = act_pattern;
                    r_nxt.last     = act_last;
                    r_nxt.idx      = '0;
                    r_nxt.acc      = '0;
                    r_nxt.st       = ST_RUN;
                    fin            = (plen == ZERO_BYTE); // Empty action passes
                end
            end
            ST_RUN: begin
                if (bv && !bp && room) begin
                    case (r_r.op)
                        OP_CAPTURE: begin
                            if (r_r.end_en && bd == r_r.end_char) begin
                                if (r_r.idx < r_r.count) begin
                                    r_nxt.st = ST_FILL;
                                end else begin
                                    fin = 1'b1;
                                end
                            end else begin
                                push      = 1'b1;
                                push_w    = {1'b0, r_r.idx, 8'h00, bd};
                                r_nxt.idx = r_r.idx + 1'b1;
                                fin       = (r_r.idx + 1'b1 == r_r.count);
                            end
                        end
                        OP_WAIT_LIT, OP_WAIT_ARR: begin
                            // Exact compare, no case folding
                            if (bd == pbyte) begin
                                r_nxt.idx = r_r.idx + 1'b1;
                                fin = (r_r.idx + 1'b1 == r_r.len);
                            end else if (bd == r_r.pat[7:0]) begin
                                r_nxt.idx = 8'h01;
                            end else begin
                                r_nxt.idx = '0;
                            end
                        end
                        OP_SKIP: begin
                            r_nxt.idx = r_r.idx + 1'b1;
                            fin       = (r_r.idx + 1'b1 == r_r.count);
                        end
                        OP_DEC_FIXED, OP_DEC_VAR: begin
                            if (is_digit) begin
                                r_nxt.acc = dec_next;
                                r_nxt.idx = r_r.idx + 1'b1;
                                if (r_r.op == OP_DEC_FIXED &&
                                    r_r.idx + 1'b1 == r_r.count) begin
                                    push   = 1'b1;
                                    push_w = {1'b1, 8'h00, dec_next};
                                    fin    = 1'b1;
                                end
                            end else if (r_r.idx != '0) begin
                                // Non-numeric ends a started number
                                push   = 1'b1;
                                push_w = {1'b1, 8'h00, r_r.acc};
                                fin    = 1'b1;
                            end
                        end
                        default: fin = 1'b1;
                    endcase
                end
            end
            ST_FILL: begin
                if (room) begin
                    push      = 1'b1;
                    push_w    = {1'b0, r_r.idx, 8'h00, ZERO_BYTE};
                    r_nxt.idx = r_r.idx + 1'b1;
                    fin       = (r_r.idx + 1'b1 == r_r.count);
                end
            end
            default: r_nxt.st = ST_IDLE;
        endcase

        // Next action or completion, in listed order
        if (fin) begin
            r_nxt.st   = r_nxt.last ? ST_IDLE : ST_FETCH; // Fetch sees the new action's flag
            r_nxt.done = r_nxt.last;
        end

        // Inactivity timer: any byte restarts it
        if (r_r.st != ST_IDLE) begin
            if (bv) begin
                r_nxt.ms_cnt = '0;
                r_nxt.presc  = '0;
            end else if (r_r.presc == PRESC_TOP) begin
                r_nxt.presc  = '0;
                r_nxt.ms_cnt = r_r.ms_cnt + 1'b1;
            end else begin
                r_nxt.presc  = r_r.presc + 1'b1;
            end
        end

        // Abort exits; parity wins over everything else
        if (r_r.st != ST_IDLE) begin
            if (bv && bp) begin
                r_nxt.st   = ST_IDLE;
                r_nxt.perr = 1'b1;
                r_nxt.done = 1'b0;
            end else if (timeout_ms != '0 && r_r.ms_cnt >= timeout_ms) begin
                r_nxt.st   = ST_IDLE;
                r_nxt.tmo  = 1'b1;
                r_nxt.done = 1'b0;
            end
        end

        // Two-entry buffer: entry 0 is always the head
        case ({push, pop})
            2'b10: begin
                if (r_r.bcnt == 2'h0) begin
                    r_nxt.e0 = push_w;
                end else begin
                    r_nxt.e1 = push_w;
                end
                r_nxt.bcnt = r_r.bcnt + 1'b1;
            end
            2'b01: begin
                r_nxt.e0   = r_r.e1;
                r_nxt.bcnt = r_r.bcnt - 1'b1;
            end
            2'b11: begin
                if (r_r.bcnt == 2'h1) begin
                    r_nxt.e0 = push_w;
                end else begin
                    r_nxt.e0 = r_r.e1;
                    r_nxt.e1 = push_w;
                end
            end
            default: r_nxt.bcnt = r_r.bcnt;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_r <= '{st: ST_IDLE, op: OP_CAPTURE, default: '0};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign op_busy      = (r_r.st != ST_IDLE);
    assign act_ready    = (r_r.st == ST_FETCH);
    assign out_valid    = (r_r.bcnt != 2'h0);
    assign out_is_value = r_r.e0[24];
    assign out_addr     = r_r.e0[23:16];
    assign out_data     = r_r.e0[15:0];
    assign done_pulse   = r_r.done;
    assign parity_exit  = r_r.perr;
    assign timeout_exit = r_r.tmo;

    // Checks on the sequencer behaviour
    a_parity_abort: assert property (@(posedge clk) disable iff (rst)
        (bv && bp && r_r.st != ST_IDLE) |=> (parity_exit && !op_busy && !done_pulse))
        else $error("parity error did not abort");
    a_end_not_stored: assert property (@(posedge clk) disable iff (rst)
        (r_r.st == ST_RUN && r_r.op == OP_CAPTURE && r_r.end_en && bv
         && bd == r_r.end_char) |-> !push)
        else $error("end character stored");
    a_fill_zero: assert property (@(posedge clk) disable iff (rst)
        (push && r_r.st == ST_FILL) |-> (push_w[7:0] == ZERO_BYTE && !push_w[24]))
        else $error("fill wrote nonzero");
    a_skip_quiet: assert property (@(posedge clk) disable iff (rst)
        (r_r.st == ST_RUN && r_r.op == OP_SKIP) |-> !push)
        else $error("skip stored a byte");
    a_byte_restart: assert property (@(posedge clk) disable iff (rst)
        (bv && r_r.st != ST_IDLE) |=> (r_r.ms_cnt == '0 && r_r.presc == '0))
        else $error("byte did not restart timer");
    a_no_timeout: assert property (@(posedge clk) disable iff (rst)
        (timeout_ms == '0) |=> !timeout_exit)
        else $error("timeout without setting");
    a_dec_count: assert property (@(posedge clk) disable iff (rst)
        (r_r.st == ST_RUN && r_r.op == OP_DEC_FIXED) |-> (r_r.idx < r_r.count))
        else $error("too many digits");
    a_exit_single: assert property (@(posedge clk) disable iff (rst)
        $onehot0({done_pulse, parity_exit, timeout_exit}))
        else $error("two exits at once");
    a_buf_bound: assert property (@(posedge clk) disable iff (rst)
        (r_r.bcnt == BUF_DEPTH && !out_ready) |=> (r_r.bcnt == BUF_DEPTH && $stable(r_r.e0)))
        else $error("buffer overran");
    c_done: cover property (@(posedge clk) disable iff (rst) done_pulse);
    c_parity: cover property (@(posedge clk) disable iff (rst) parity_exit);
    c_timeout: cover property (@(posedge clk) disable iff (rst) timeout_exit);
    c_full: cover property (@(posedge clk) disable iff (rst) r_r.bcnt == BUF_DEPTH);
endmodule

// ### tb/srf_sender.sv
// Serial sender model that drives byte frames onto the receive line
`timescale 1ns/1ns
module srf_sender #(
    parameter int BIT_CYC = 16
) (
    input  wire logic clk,
    output logic      rx_pin
);
    // The line idles high between frames, as a real sender leaves it
    initial rx_pin = 1'b1;

    // One bit cell: change just after an edge, hold for a whole bit time
    task automatic put(input logic v);
        @(posedge clk);
        #1 rx_pin = v;
        repeat (BIT_CYC - 1) @(posedge clk);
    endtask

    // Start bit, data LSB first, optional even parity (bad flips it), stop bit
    task automatic send(input logic [7:0] b, input bit seven, input bit par, input bit bad);
        int n;
        n = seven ? 7 : 8;
        put(1'b0);
        for (int i = 0; i < n; i++) begin
            put(b[i]);
        end
        if (par) begin
            put((seven ? ^b[6:0] : ^b) ^ bad);
        end
        put(1'b1);
    endtask

    // Frames back to back with no idle gap, the hardest case for the receiver
    task automatic send_str(input string s, input bit seven, input bit par);
        for (int i = 0; i < s.len(); i++) begin
            send(s[i], seven, par, 1'b0);
        end
    endtask
endmodule

// ### tb/srf_input_filter_tb.sv
// Self-checking bench for the serial receive input filter
`timescale 1ns/1ns
module srf_input_filter_tb;
    import srf_pkg::*;
    localparam int BIT_CYC = 16;
    localparam int MS_CYC  = 20;

    logic                   clk, rst, rx_pin, seven_bit, parity_en, op_start, op_busy;
    logic                   act_valid, act_ready, act_end_en, act_last, out_valid, out_ready;
    logic                   out_is_value, done_pulse, parity_exit, timeout_exit;
    logic [TMO_W-1:0]       timeout_ms;
    logic [2:0]             act_op;
    logic [7:0]             act_count, act_end_char, out_addr;
    logic [PAT_BYTES*8-1:0] act_pattern;
    logic [15:0]            out_data;
    logic [24:0]            got_q[$];
    logic [24:0]            exp_q[$];
    int                     num_errors, checked, cyc, n_done, n_par, n_tmo;

    srf_input_filter #(.CLKS_PER_BIT_P(BIT_CYC), .CYC_PER_MS_P(MS_CYC)) u_dut (
        .clk(clk), .rst(rst), .rx_pin(rx_pin), .seven_bit(seven_bit),
        .parity_en(parity_en), .timeout_ms(timeout_ms), .op_start(op_start),
        .op_busy(op_busy), .act_valid(act_valid), .act_ready(act_ready),
        .act_op(act_op), .act_count(act_count), .act_end_en(act_end_en),
        .act_end_char(act_end_char), .act_pattern(act_pattern), .act_last(act_last),
        .out_valid(out_valid), .out_ready(out_ready), .out_addr(out_addr),
        .out_data(out_data), .out_is_value(out_is_value), .done_pulse(done_pulse),
        .parity_exit(parity_exit), .timeout_exit(timeout_exit));

    srf_sender #(.BIT_CYC(BIT_CYC)) u_snd (.clk(clk), .rx_pin(rx_pin));

    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Collect words, count exits; the consumer stalls every other cycle
    always @(posedge clk) begin
        cyc++;
        out_ready <= #1 ~out_ready;
        if (out_valid === 1'b1 && out_ready === 1'b1) got_q.push_back({out_addr, out_data, out_is_value});
        if (done_pulse === 1'b1) n_done++;
        if (parity_exit === 1'b1) n_par++;
        if (timeout_exit === 1'b1) n_tmo++;
        if (cyc == 30000) begin
            num_errors++;
            $display("watchdog expired");
            stop_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic want(input logic [7:0] a, input logic [15:0] d, input logic v);
        exp_q.push_back({a, d, v});
    endtask

    // Starts an operation; format and limit are levels held through it
    task automatic start_op(input bit seven, input bit par, input int tmo);
        step(1);
        seven_bit = seven;
        parity_en = par;
        timeout_ms = tmo[TMO_W-1:0];
        n_done = 0;
        n_par = 0;
        n_tmo = 0;
        op_start = 1'b1;
        step(1);
        op_start = 1'b0;
    endtask

    // Offer one action and hold it until the edge that takes it
    task automatic act(input logic [2:0] op, input logic [7:0] cnt, input logic [7:0] endc,
                       input string pat, input logic last);
        act_op = op;
        act_count = cnt;
        act_end_en = (endc != 8'h00);
        act_end_char = endc;
        act_last = last;
        act_pattern = '0;
        for (int i = 0; i < pat.len(); i++) act_pattern[i*8 +: 8] = pat[i];
        act_valid = 1'b1;
        while (act_ready !== 1'b1) step(1);
        step(1);
        act_valid = 1'b0;
        step(1); // One low cycle keeps a following call off this time step
    endtask

    // Wait for the exit, let the buffer drain, then judge exits and words
    task automatic finish_op(input string name, input int d, input int p, input int t);
        while (op_busy === 1'b1) step(1);
        step(8);
        check({name, " done"}, n_done, d);
        check({name, " parity exit"}, n_par, p);
        check({name, " timeout exit"}, n_tmo, t);
        check({name, " words"}, got_q.size(), exp_q.size());
        foreach (exp_q[i]) begin
            if (i < got_q.size()) check({name, " word"}, got_q[i], exp_q[i]);
        end
        got_q.delete();
        exp_q.delete();
        $display("test %s finished", name);
    endtask

    // Capture ended early by the end character, after a long idle wait
    task automatic t_capture();
        start_op(1'b0, 1'b0, 0);
        act(OP_CAPTURE, 8'h05, 8'h2A, "", 1'b1);
        step(3000);
        check("idle without limit", op_busy, 1'b1);
        u_snd.send_str("hi*", 1'b0, 1'b0);
        want(8'h00, 16'h0068, 1'b0);
        want(8'h01, 16'h0069, 1'b0);
        for (int i = 2; i < 5; i++) want(i[7:0], 16'h0000, 1'b0);
        finish_op("capture", 1, 0, 0);
    endtask

    // Case-sensitive label, skip, then four digits; a wrong-case label comes first
    task automatic t_compound();
        start_op(1'b0, 1'b0, 0);
        fork
            u_snd.send_str("Pos: pos: 12345678", 1'b0, 1'b0);
            begin
                act(OP_WAIT_LIT, 8'h05, 8'h00, "pos: ", 1'b0);
                act(OP_SKIP, 8'h04, 8'h00, "", 1'b0);
                act(OP_DEC_FIXED, 8'h04, 8'h00, "", 1'b1);
            end
        join
        want(8'h00, 16'h162E, 1'b1);
        finish_op("compound", 1, 0, 0);
    endtask

    // Eight data bits plus parity: zero-ended pattern, then three of four pattern bytes
    task automatic t_array();
        start_op(1'b0, 1'b1, 0);
        fork
            u_snd.send_str("xokabc45;", 1'b0, 1'b1);
            begin
                act(OP_WAIT_ARR, 8'h00, 8'h00, "ok", 1'b0);
                act(OP_WAIT_ARR, 8'h03, 8'h00, "abc4", 1'b0);
                act(OP_DEC_VAR, 8'h00, 8'h00, "", 1'b1);
            end
        join
        want(8'h00, 16'h002D, 1'b1);
        finish_op("array", 1, 0, 0);
    endtask

    // Seven-bit even parity with a limit set; the second byte has bad parity
    task automatic t_parity();
        start_op(1'b1, 1'b1, 10);
        act(OP_CAPTURE, 8'h03, 8'h00, "", 1'b1);
        u_snd.send(8'h41, 1'b1, 1'b1, 1'b0);
        u_snd.send(8'h42, 1'b1, 1'b1, 1'b1);
        want(8'h00, 16'h0041, 1'b0);
        finish_op("parity", 0, 1, 0);
    endtask

    // Empty skip passes at once; letters keep the limit off, silence then ends it
    task automatic t_timeout();
        start_op(1'b1, 1'b1, 10);
        act(OP_SKIP, 8'h00, 8'h00, "", 1'b0);
        act(OP_DEC_VAR, 8'h00, 8'h00, "", 1'b1);
        u_snd.send_str("ABCD", 1'b1, 1'b1);
        check("no early timeout", n_tmo, 0);
        step(150);
        check("busy before limit", op_busy, 1'b1);
        step(100);
        check("idle after limit", op_busy, 1'b0);
        finish_op("timeout", 0, 0, 1);
    endtask

    // Reset, then run every scenario in turn
    initial begin
        rst = 1'b1;
        out_ready = 1'b0;
        op_start = 1'b0;
        act_valid = 1'b0;
        act_op = 3'h0;
        act_count = 8'h00;
        act_end_en = 1'b0;
        act_end_char = 8'h00;
        act_pattern = '0;
        act_last = 1'b0;
        seven_bit = 1'b0;
        parity_en = 1'b0;
        timeout_ms = '0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        step(2);
        t_capture();
        t_compound();
        t_array();
        t_parity();
        t_timeout();
        stop_test();
    end
endmodule
